// ### core/gpctr_cfg.svh
// Register offsets, field positions and reset values of the counter block
`ifndef GPCTR_CFG_SVH
`define GPCTR_CFG_SVH
`define GPCTR_OFF_CTRL    4'h0
`define GPCTR_OFF_CMD     4'h1
`define GPCTR_OFF_STAT    4'h2
`define GPCTR_OFF_COUNT   4'h3
`define GPCTR_OFF_SAVE    4'h4
`define GPCTR_NUM_REGS    2
`define GPCTR_NUM_INPUTS  7
`define GPCTR_CTRL_RESET  32'h0000_0000
`define GPCTR_F_MODE_LO   0
`define GPCTR_F_SRCPOL    2
`define GPCTR_F_GATEPOL   3
`define GPCTR_F_PAUSEEN   4
`define GPCTR_F_DIR_LO    5
`define GPCTR_F_SRCSEL_LO 8
`define GPCTR_F_GATESEL_LO 11
`define GPCTR_F_DIRSEL_LO 14
`define GPCTR_F_BUFPW     17
`define GPCTR_CMD_ARM     0
`define GPCTR_CMD_DISARM  1
`endif

// ### core/gpctr_pkg.sv
// Types shared by the counter block
package gpctr_pkg;
   typedef enum logic [1:0]
   {
      GPCTR_MODE_EDGE = 2'h0,
      GPCTR_MODE_BUFEDGE = 2'h1,
      GPCTR_MODE_PULSE = 2'h3
   } gpctr_mode_t;
   typedef enum logic [1:0]
   {
      GPCTR_DIR_UP = 2'h0,
      GPCTR_DIR_DOWN = 2'h1,
      GPCTR_DIR_PIN = 2'h3
   } gpctr_dir_t;
   typedef enum logic [1:0]
   {
      GPCTR_PW_IDLE = 2'h0,
      GPCTR_PW_WAIT = 2'h1,
      GPCTR_PW_MEAS = 2'h3,
      GPCTR_PW_DONE = 2'h2
   } gpctr_pw_t;
endpackage

// ### core/gpctr_buf2.sv
// Two-entry valid/ready buffer for captured counts
`timescale 1ns/1ns
module gpctr_buf2 #(
   parameter int WIDTH = 32
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] mem_q [0:1];
   logic rdPtr_q;
   logic wrPtr_q;
   logic [1:0] used_q;
   logic doWr;
   logic doRd;

   assign inReady = (used_q != 2'h2);
   assign outValid = (used_q != 2'h0);
   assign outData = mem_q[rdPtr_q];
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;

   always_ff @(posedge clk)
   begin
      if (doWr)
      begin
         mem_q[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdPtr_q <= 1'b0;
         wrPtr_q <= 1'b0;
         used_q <= 2'h0;
      end
      else
      begin
         if (doWr)
         begin
            wrPtr_q <= ~wrPtr_q;
         end
         if (doRd)
         begin
            rdPtr_q <= ~rdPtr_q;
         end
         if (doWr && !doRd)
         begin
            used_q <= used_q + 2'h1;
         end
         else if (doRd && !doWr)
         begin
            used_q <= used_q - 2'h1;
         end
      end
   end
endmodule

// ### core/gpctr_top.sv
// Two general-purpose 32-bit edge counters with pulse-width and buffered capture
// How it works
// - Two independent counters, each with a 32-bit count.
// - Each counter selects its inputs among seven input lines.
// - Once armed, count source edges of a chosen polarity.
// - Software reads the live count without disturbing counting.
// - In plain edge mode only, source edges are ignored while the pause level stands on gate.
// - Pause comes from the gate input, with selectable active level.
// - Buffered mode captures the count on each sample edge, streams it out.
// - Captured counts are cumulative since arming; sampling never clears.
// - The sample clock is the gate input, rising or falling edge.
// - Buffered counting starts at arming, before the first sample edge.
// - Direction is up, down, or steered by the direction input.
// - Pulse-width measures gate pulses, high or low as configured.
// - Pulse-width counts source edges only while gate is active.
// - A pulse already active at arming is skipped.
// - Single pulse mode latches count at gate end, then stops.
// - Buffered pulse mode latches count on every trailing gate edge.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
`include "gpctr_cfg.svh"
module gpctr_top #(
   parameter int NUM_IN = `GPCTR_NUM_INPUTS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_IN-1:0] sigIn,
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitRequest,
   output logic [1:0] dmaValid,
   input wire logic [1:0] dmaReady,
   output logic [63:0] dmaData
);
   import gpctr_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [NUM_IN-1:0] syncA_q;
   logic [NUM_IN-1:0] syncB_q;
   logic [NUM_IN-1:0] syncC_q;
   logic [NUM_IN-1:0] level_q;
   logic [NUM_IN-1:0] levelPrev_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         syncA_q <= '0;
         syncB_q <= '0;
         syncC_q <= '0;
         level_q <= '0;
         levelPrev_q <= '0;
      end
      else
      begin
         syncA_q <= sigIn;
         syncB_q <= syncA_q;
         syncC_q <= syncB_q;
         // A change counts once the second and third stages agree
         level_q <= (syncB_q & syncC_q) | (level_q & (syncB_q | syncC_q));
         levelPrev_q <= level_q;
      end
   end

   function automatic logic pickLine(input logic [NUM_IN-1:0] lines, input logic [2:0] sel);
      logic [7:0] wide;
      wide = 8'(lines);
      return wide[sel];
   endfunction

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   logic [31:0] ctrl_q [0:`GPCTR_NUM_REGS-1];
   logic [`GPCTR_NUM_REGS-1:0] armCmd;
   logic [`GPCTR_NUM_REGS-1:0] disarmCmd;
   logic [31:0] count_q [0:`GPCTR_NUM_REGS-1];
   logic [31:0] save_q [0:`GPCTR_NUM_REGS-1];
   logic [`GPCTR_NUM_REGS-1:0] armed_q;
   logic [`GPCTR_NUM_REGS-1:0] saveValid_q;
   logic [`GPCTR_NUM_REGS-1:0] overrun_q;
   logic rdPend_q;
   logic ch;
   logic [3:0] reg4;
   logic [31:0] rdMux;

   // Byte address: bit 5 picks the counter, bits 4:2 the register
   assign ch = avsAddress[5];
   assign reg4 = {1'b0, avsAddress[4:2]};
   // Reads take one wait cycle, writes none
   assign avsWaitRequest = avsRead && !rdPend_q;

   always_comb
   begin
      rdMux = 32'h0000_0000;
      if (reg4 == `GPCTR_OFF_CTRL)
      begin
         rdMux = ctrl_q[ch];
      end
      else if (reg4 == `GPCTR_OFF_STAT)
      begin
         rdMux = {29'h0, overrun_q[ch], saveValid_q[ch], armed_q[ch]};
      end
      else if (reg4 == `GPCTR_OFF_COUNT)
      begin
         rdMux = count_q[ch];
      end
      else if (reg4 == `GPCTR_OFF_SAVE)
      begin
         rdMux = save_q[ch];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdPend_q <= 1'b0;
         avsReadData <= 32'h0000_0000;
      end
      else
      begin
         rdPend_q <= avsRead && !rdPend_q;
         if (avsRead && !rdPend_q)
         begin
            avsReadData <= rdMux;
         end
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int c = 0; c < `GPCTR_NUM_REGS; c++)
         begin
            ctrl_q[c] <= `GPCTR_CTRL_RESET;
         end
      end
      else if (avsWrite && reg4 == `GPCTR_OFF_CTRL)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (avsByteEnable[b])
            begin
               ctrl_q[ch][b*8 +: 8] <= avsWriteData[b*8 +: 8];
            end
         end
      end
   end

   always_comb
   begin
      armCmd = '0;
      disarmCmd = '0;
      if (avsWrite && reg4 == `GPCTR_OFF_CMD && avsByteEnable[0])
      begin
         armCmd[ch] = avsWriteData[`GPCTR_CMD_ARM];
         disarmCmd[ch] = avsWriteData[`GPCTR_CMD_DISARM];
      end
   end

   // ----------------------------------------------------------------
   // Counter channels
   // ----------------------------------------------------------------
   logic [`GPCTR_NUM_REGS-1:0] capReady;
   gpctr_pw_t pw_q [0:`GPCTR_NUM_REGS-1];

   for (genvar g = 0; g < `GPCTR_NUM_REGS; g++)
   begin : chan
      gpctr_mode_t mode;
      gpctr_dir_t dirSel;
      logic srcPol;
      logic gatePol;
      logic pauseEn;
      logic bufPw;
      logic srcLvl;
      logic gateLvl;
      logic dirLvl;
      logic srcWas;
      logic gateWas;
      logic srcEdge;
      logic gateAct;
      logic gateStart;
      logic gateEnd;
      logic up;
      logic countEn;
      logic capture;
      logic [31:0] nextCount;

      assign mode = gpctr_mode_t'(ctrl_q[g][`GPCTR_F_MODE_LO +: 2]);
      assign dirSel = gpctr_dir_t'(ctrl_q[g][`GPCTR_F_DIR_LO +: 2]);
      assign srcPol = ctrl_q[g][`GPCTR_F_SRCPOL];
      assign gatePol = ctrl_q[g][`GPCTR_F_GATEPOL];
      assign pauseEn = ctrl_q[g][`GPCTR_F_PAUSEEN];
      assign bufPw = ctrl_q[g][`GPCTR_F_BUFPW];
      // Input selection among the seven lines; out-of-range picks read low
      assign srcLvl = pickLine(level_q, ctrl_q[g][`GPCTR_F_SRCSEL_LO +: 3]);
      assign gateLvl = pickLine(level_q, ctrl_q[g][`GPCTR_F_GATESEL_LO +: 3]);
      assign dirLvl = pickLine(level_q, ctrl_q[g][`GPCTR_F_DIRSEL_LO +: 3]);
      assign srcWas = pickLine(levelPrev_q, ctrl_q[g][`GPCTR_F_SRCSEL_LO +: 3]);
      assign gateWas = pickLine(levelPrev_q, ctrl_q[g][`GPCTR_F_GATESEL_LO +: 3]);
      // Polarity 0 selects rising / high, 1 selects falling / low
      assign srcEdge = (srcLvl != srcWas) && (srcLvl == !srcPol);
      assign gateAct = (gateLvl == !gatePol);
      assign gateStart = gateAct && (gateWas != gateLvl);
      assign gateEnd = !gateAct && (gateWas != gateLvl);
      assign up = (dirSel == GPCTR_DIR_UP) || (dirSel == GPCTR_DIR_PIN && dirLvl);

      always_comb
      begin
         countEn = 1'b0;
         capture = 1'b0;
         if (armed_q[g])
         begin
            case (mode)
               GPCTR_MODE_EDGE:
               begin
                  countEn = srcEdge && !(pauseEn && gateAct);
               end
               GPCTR_MODE_BUFEDGE:
               begin
                  countEn = srcEdge;
                  capture = gateStart;
               end
               GPCTR_MODE_PULSE:
               begin
                  countEn = srcEdge && gateAct && pw_q[g] == GPCTR_PW_MEAS;
                  capture = gateEnd && pw_q[g] == GPCTR_PW_MEAS;
               end
               default:
               begin
               end
            endcase
         end
      end

      // Wraps modulo 2^32 in both directions
      assign nextCount = up ? count_q[g] + 32'h1 : count_q[g] - 32'h1;

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            armed_q[g] <= 1'b0;
            count_q[g] <= 32'h0000_0000;
            pw_q[g] <= GPCTR_PW_IDLE;
         end
         else if (armCmd[g])
         begin
            armed_q[g] <= 1'b1;
            count_q[g] <= 32'h0000_0000;
            pw_q[g] <= gateAct ? GPCTR_PW_WAIT : GPCTR_PW_MEAS;
         end
         else if (disarmCmd[g])
         begin
            armed_q[g] <= 1'b0;
            pw_q[g] <= GPCTR_PW_IDLE;
         end
         else if (armed_q[g])
         begin
            if (countEn)
            begin
               count_q[g] <= nextCount;
            end
            if (mode == GPCTR_MODE_PULSE)
            begin
               case (pw_q[g])
                  GPCTR_PW_WAIT:
                  begin
                     if (!gateAct)
                     begin
                        pw_q[g] <= GPCTR_PW_MEAS;
                     end
                  end
                  GPCTR_PW_MEAS:
                  begin
                     if (gateEnd)
                     begin
                        count_q[g] <= 32'h0000_0000;
                        pw_q[g] <= bufPw ? GPCTR_PW_MEAS : GPCTR_PW_DONE;
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            save_q[g] <= 32'h0000_0000;
            saveValid_q[g] <= 1'b0;
            overrun_q[g] <= 1'b0;
         end
         else
         begin
            if (capture)
            begin
               save_q[g] <= count_q[g];
               saveValid_q[g] <= 1'b1;
               if (!capReady[g])
               begin
                  overrun_q[g] <= 1'b1;
               end
            end
            else if (armCmd[g])
            begin
               saveValid_q[g] <= 1'b0;
               overrun_q[g] <= 1'b0;
            end
         end
      end

      gpctr_buf2 #(
         .WIDTH(32)
      ) u_buf (
         .clk(clk),
         .rst(rst),
         .inValid(capture),
         .inReady(capReady[g]),
         .inData(count_q[g]),
         .outValid(dmaValid[g]),
         .outReady(dmaReady[g]),
         .outData(dmaData[g*32 +: 32])
      );
   end
endmodule

// ### verification/gpctr_chk.sv
// Bus and capture-stream assertions of the counter block
`timescale 1ns/1ns
module gpctr_chk #(
   parameter int NUM_IN = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_IN-1:0] sigIn,
   input wire logic [5:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   input wire logic [31:0] avsReadData,
   input wire logic avsWaitRequest,
   input wire logic [1:0] dmaValid,
   input wire logic [1:0] dmaReady,
   input wire logic [63:0] dmaData
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_write_no_wait: assert property (avsWrite |-> !avsWaitRequest)
      else $error("write was stalled");
   a_read_first_wait: assert property ($rose(avsRead) |-> avsWaitRequest)
      else $error("read answered without wait cycle");
   a_wait_one_cycle: assert property (avsWaitRequest |=> !avsWaitRequest)
      else $error("wait held beyond one cycle");
   a_wait_idle_low: assert property (!avsRead |-> !avsWaitRequest)
      else $error("wait raised without read");
   a_rdata_held: assert property (!avsRead |=> $stable(avsReadData))
      else $error("read data changed without read");
   a_write_keeps_rdata: assert property (avsWrite |=> $stable(avsReadData))
      else $error("write disturbed read data");
   a_dma0_stall_hold: assert property (dmaValid[0] && !dmaReady[0] |=>
      dmaValid[0] && $stable(dmaData[31:0]))
      else $error("stream 0 word lost under stall");
   a_dma1_stall_hold: assert property (dmaValid[1] && !dmaReady[1] |=>
      dmaValid[1] && $stable(dmaData[63:32]))
      else $error("stream 1 word lost under stall");
endmodule

// ### verification/gpctr_sig_model.sv
// Source, gate and direction signal generator facing the counter inputs
`timescale 1ns/1ns
module gpctr_sig_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic srcRun,
   input wire logic gateLvl,
   input wire logic dirLvl,
   output logic [6:0] sigOut
);
   logic [2:0] phaseQ;
   logic [3:0] noiseQ;
   // Source: 4 clocks low, 4 high while running, low when stopped
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         phaseQ <= 3'h0;
      else if (!srcRun)
         phaseQ <= 3'h0;
      else
         phaseQ <= phaseQ + 3'h1;
   end
   // Unused lines carry a counter stepping by 5 each cycle so no stale level hides a bad select
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         noiseQ <= 4'h0;
      else
         noiseQ <= noiseQ + 4'h5;
   end
   assign sigOut = {noiseQ, dirLvl, gateLvl, srcRun & phaseQ[2]};
endmodule

// ### verification/gpctr_top_tb_top.sv
// Self-checking bench of the counter block
`timescale 1ns/1ns
module gpctr_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [5:0] avsAddress = 6'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWriteData = 32'h0;
   logic [3:0] avsByteEnable = 4'hF;
   logic [31:0] avsReadData;
   logic avsWaitRequest;
   logic [1:0] dmaValid;
   logic [1:0] dmaReady = 2'h0;
   logic [63:0] dmaData;
   logic [6:0] sigIn;
   logic srcRun = 1'b0;
   logic gateLvl = 1'b0;
   logic dirLvl = 1'b0;
   int errCount = 0;
   int checksDone = 0;
   // Columns: control word, gate, direction, source pulses, expected count
   logic [31:0] rowTab [0:6][0:4] = '{
      '{32'h0000_8800, 32'h0, 32'h0, 32'h5, 32'h0000_0005},
      '{32'h0000_8804, 32'h0, 32'h0, 32'h3, 32'h0000_0003},
      '{32'h0000_8820, 32'h0, 32'h0, 32'h2, 32'hFFFF_FFFE},
      '{32'h0000_8860, 32'h0, 32'h1, 32'h4, 32'h0000_0004},
      '{32'h0000_8860, 32'h0, 32'h0, 32'h1, 32'hFFFF_FFFF},
      '{32'h0000_8810, 32'h1, 32'h0, 32'h4, 32'h0000_0000},
      '{32'h0000_8818, 32'h1, 32'h0, 32'h4, 32'h0000_0004}};

   gpctr_sig_model i_model (.clk(clk), .rst(rst), .srcRun(srcRun), .gateLvl(gateLvl),
      .dirLvl(dirLvl), .sigOut(sigIn));
   gpctr_top i_dut (.clk(clk), .rst(rst), .sigIn(sigIn), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
      .avsWaitRequest(avsWaitRequest), .dmaValid(dmaValid), .dmaReady(dmaReady),
      .dmaData(dmaData));

   initial
   begin
      forever #4 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         errCount++;
      end
   endtask

   task automatic waitAck();
      do
      begin
         @(posedge clk);
      end
      while (avsWaitRequest !== 1'b0);
   endtask

   task automatic busWrite(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk);
      avsAddress <= a;
      avsWriteData <= d;
      avsWrite <= 1'b1;
      waitAck();
      avsWrite <= 1'b0;
   endtask

   task automatic rdChk(input string name, input logic [5:0] a, input logic [31:0] exp);
      @(posedge clk);
      avsAddress <= a;
      avsRead <= 1'b1;
      waitAck();
      check(name, exp, avsReadData);
      avsRead <= 1'b0;
   endtask

   task automatic lvl(input logic g, input logic d);
      @(posedge clk);
      gateLvl <= g;
      dirLvl <= d;
      repeat (8) @(posedge clk);
   endtask

   task automatic pulses(input int n);
      @(posedge clk);
      srcRun <= 1'b1;
      repeat (n * 8) @(posedge clk);
      srcRun <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   task automatic pop(input int i, input logic [31:0] exp);
      @(posedge clk);
      check("stream valid", 32'h1, {31'h0, dmaValid[i]});
      check("stream word", exp, dmaData[i*32 +: 32]);
      dmaReady[i] <= 1'b1;
      @(posedge clk);
      dmaReady[i] <= 1'b0;
   endtask

   task automatic testDone();
      $display("checks %0d mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      #400000;
      errCount++;
      testDone();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      rdChk("ctrl reset", 6'h00, 32'h0);
      rdChk("status reset", 6'h08, 32'h0);
      rdChk("unmapped", 6'h1C, 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         busWrite(6'h00, rowTab[i][0]);
         lvl(rowTab[i][1][0], rowTab[i][2][0]);
         busWrite(6'h04, 32'h1);
         pulses(rowTab[i][3]);
         rdChk("edge count", 6'h0C, rowTab[i][4]);
      end
      rdChk("unarmed count", 6'h2C, 32'h0);
      // Buffered edge counting with the sink stalled until overrun
      busWrite(6'h00, 32'h0000_8801);
      lvl(1'b0, 1'b0);
      busWrite(6'h04, 32'h1);
      pulses(3);
      lvl(1'b1, 1'b0);
      rdChk("live count", 6'h0C, 32'h3);
      pulses(2);
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      pulses(1);
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      rdChk("kept count", 6'h0C, 32'h6);
      rdChk("status", 6'h08, 32'h7);
      pop(0, 32'h3);
      pop(0, 32'h5);
      @(posedge clk);
      check("drained", 32'h0, {31'h0, dmaValid[0]});
      // Pulse width: single on counter 0, buffered on counter 1
      busWrite(6'h00, 32'h0000_8803);
      busWrite(6'h20, 32'h0002_8803);
      lvl(1'b1, 1'b0);
      busWrite(6'h04, 32'h1);
      busWrite(6'h24, 32'h1);
      pulses(2);
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      pulses(3);
      lvl(1'b0, 1'b0);
      lvl(1'b1, 1'b0);
      pulses(2);
      lvl(1'b0, 1'b0);
      rdChk("single width", 6'h10, 32'h3);
      pop(1, 32'h3);
      pop(1, 32'h2);
      // Disarmed and finished counters ignore source and gate
      busWrite(6'h24, 32'h2);
      rdChk("disarmed status", 6'h28, 32'h2);
      lvl(1'b1, 1'b0);
      pulses(2);
      lvl(1'b0, 1'b0);
      rdChk("disarmed count", 6'h2C, 32'h0);
      rdChk("done count", 6'h0C, 32'h0);
      rdChk("done save", 6'h10, 32'h3);
      // Byte lane 1 only reaches the control register
      avsByteEnable <= 4'h2;
      busWrite(6'h20, 32'hFFFF_FFFF);
      avsByteEnable <= 4'hF;
      rdChk("lane write", 6'h20, 32'h0002_FF03);
      // Reset in mid-run clears control, status and streams
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("stream after reset", 32'h0, {30'h0, dmaValid});
      rdChk("ctrl after reset", 6'h20, 32'h0);
      rdChk("status after reset", 6'h08, 32'h0);
      testDone();
   end
endmodule

bind gpctr_top gpctr_chk #(.NUM_IN(NUM_IN)) i_chk (.clk(clk), .rst(rst), .sigIn(sigIn),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
   .avsWaitRequest(avsWaitRequest), .dmaValid(dmaValid), .dmaReady(dmaReady),
   .dmaData(dmaData));
